// ### bench/imm_assertions.sv
// checker watching the integrity monitor ports
module imm_assertions (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic MEM_REQ,
    input wire logic MEM_WE,
    input wire logic [31:0] MEM_ADDR,
    input wire logic [31:0] MEM_WDATA,
    input wire logic MEM_ACK,
    input wire logic IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // ----------------------------------------
    // helper: an enable write has been seen
    // ----------------------------------------
    logic en_seen_r;
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            en_seen_r <= 1'b0;
        end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == imm_pkg::OFF_CTRL
            && PWDATA[imm_pkg::CTRL_EN]) begin
            en_seen_r <= 1'b1;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_setup_ready;
        PSEL && !PENABLE |=> PREADY;
    endproperty
    a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
    property p_ready_cause;
        PREADY |-> $past(PSEL && !PENABLE);
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
    property p_err_map;
        PREADY && PADDR[1:0] == 2'b00 |-> PSLVERR == (PADDR > imm_pkg::OFF_ICR);
    endproperty
    a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
    property p_err_data;
        PSLVERR |-> PREADY && PRDATA == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("refused access not clean");
    property p_req_hold;
        MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE)
            && $stable(MEM_WDATA);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("memory request changed early");
    property p_ack_drop;
        MEM_ACK |=> !MEM_REQ;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("request kept after ack");
    property p_word_align;
        MEM_REQ |-> MEM_ADDR[1:0] == 2'b00;
    endproperty
    a_word_align: assert property (p_word_align) else $error("unaligned word");
    property p_fetch_after_en;
        MEM_REQ |-> en_seen_r;
    endproperty
    a_fetch_after_en: assert property (p_fetch_after_en) else $error("fetch before enable");
    property p_irq_fall;
        $fell(IRQ) |-> $past(PSEL && PENABLE && PWRITE) || $past(PSEL && PENABLE && PWRITE, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
    c_write_back: cover property (MEM_REQ && MEM_WE && MEM_ACK);
    c_irq: cover property ($rose(IRQ));
    c_refused: cover property (PSLVERR);
endmodule

bind imm_top imm_assertions u_chk (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .IRQ(IRQ));

// ### bench/imm_mem_model.sv
// system memory model answering the monitor's word requests
module imm_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic we,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    output logic ack,
    output logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:4095];
    int rd_cnt [0:4095];
    int wait_cyc = 0;
    int cnt = 0;
    initial begin
        ack = 1'b0;
        rdata = 32'h0;
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 32'h0;
            rd_cnt[i] = 0;
        end
    end
    // released data lines toggle to the inverse each cycle, so the stale word returns every other cycle
    always @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (rst) begin
            cnt <= 0;
        end else if (req && !ack && cnt < wait_cyc) begin
            cnt <= cnt + 1;
        end else if (req && !ack) begin
            cnt <= 0;
            ack <= 1'b1;
            if (we) begin
                mem[addr[13:2]] <= wdata;
            end else begin
                rdata <= mem[addr[13:2]];
                rd_cnt[addr[13:2]] <= rd_cnt[addr[13:2]] + 1;
            end
        end
    end
endmodule

// ### bench/tb.sv
// testbench: register access, descriptor list walks, interrupts
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic REF_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e;
    logic MEM_REQ, MEM_WE, MEM_ACK, IRQ;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, q;
    int num_errors = 0;
    int check_count = 0;
    localparam logic [0:4][31:0] SHA1_ABC = {32'hA9993E36, 32'h4706816A, 32'hBA3E2571,
        32'h7850C26C, 32'h9CD0D89D};
    localparam logic [0:6][31:0] SHA224_ABC = {32'h23097D22, 32'h3405D822, 32'h8642A477,
        32'hBDA255B3, 32'h2AADBCE4, 32'hBDA0B3F7, 32'hE36C9DA7};
    imm_top dut (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
        .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .IRQ(IRQ));
    imm_mem_model mem (.clk(REF_CLK), .rst(RST), .req(MEM_REQ), .we(MEM_WE),
        .addr(MEM_ADDR), .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA));
    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PADDR <= a;
        PWRITE <= w;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        @(posedge REF_CLK);
        while (PREADY !== 1'b1) @(posedge REF_CLK);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        apb(a, 1'b0, 32'h0);
        chk(q, exp, msg);
    endtask
    function automatic logic [31:0] sum_rd(input int lo, input int hi);
        int s = 0;
        for (int i = lo; i <= hi; i++) s += mem.rd_cnt[i];
        return 32'(s);
    endfunction
    task automatic wait_idle;
        do apb(imm_pkg::OFF_STAT, 1'b0, 32'h0); while (q[1:0] !== 2'b00);
    endtask
    task automatic setup(input int idx, input logic [31:0] cfg, input logic [31:0] ctl);
        mem.mem[idx] = 32'h0000_0800;
        mem.mem[idx + 1] = cfg;
        mem.mem[idx + 2] = ctl;
        for (int i = 0; i < 4096; i++) mem.rd_cnt[i] = 0;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        rd_chk(imm_pkg::OFF_STAT, 32'h0, "stat after reset");
        rd_chk(imm_pkg::OFF_IER, 32'h0, "ier after reset");
        rd_chk(imm_pkg::OFF_ISR, 32'h0, "isr after reset");
        apb(imm_pkg::OFF_DSCR, 1'b1, 32'h0000_0100);
        apb(imm_pkg::OFF_HASH, 1'b1, 32'h0000_0400);
        rd_chk(imm_pkg::OFF_DSCR, 32'h0000_0100, "list base");
        rd_chk(imm_pkg::OFF_HASH, 32'h0000_0400, "digest base");
        apb(8'h1C, 1'b1, 32'hFFFF_FFFF);
        chk({31'h0, e}, 32'h1, "unmapped write refused");
        rd_chk(8'h1C, 32'h0, "unmapped read");
        chk({31'h0, e}, 32'h1, "unmapped read refused");
        $display("test regs done");
    endtask
    task automatic t_list;
        mem.mem[12'h200] = 32'h6162_6380;
        mem.mem[12'h20F] = 32'h0000_0018;
        for (int i = 0; i < 7; i++) mem.mem[12'h110 + i] = SHA224_ABC[i];
        mem.mem[12'h105] = 32'hA5A5_A5A5;
        setup(12'h4C, 32'h0000_0036, 32'h0);
        setup(12'h48, 32'h0000_0024, 32'h0);
        setup(12'h44, 32'h0000_0010, 32'h2);
        setup(12'h40, 32'h0000_0000, 32'h0);
        apb(imm_pkg::OFF_CTRL, 1'b1, 32'h1);
        wait_idle;
        for (int i = 0; i < 5; i++) chk(mem.mem[12'h100 + i], SHA1_ABC[i], "sha1 digest");
        chk(mem.mem[12'h105], 32'hA5A5_A5A5, "digest width");
        chk(sum_rd(12'h200, 12'h22F), 32'd96, "block reads");
        chk(sum_rd(12'h40, 12'h4F), 32'd16, "descriptor reads");
        chk(sum_rd(12'h110, 12'h11F), 32'd15, "reference reads");
        rd_chk(imm_pkg::OFF_ISR, 32'h0000_0018, "mismatch and end");
        chk({31'h0, IRQ}, 32'h0, "masked irq");
        $display("test list done");
    endtask
    task automatic t_irq;
        apb(imm_pkg::OFF_IER, 1'b1, 32'h0000_0008);
        repeat (2) @(posedge REF_CLK);
        chk({31'h0, IRQ}, 32'h1, "unmasked irq");
        apb(imm_pkg::OFF_ICR, 1'b1, 32'h0000_0008);
        repeat (2) @(posedge REF_CLK);
        chk({31'h0, IRQ}, 32'h0, "irq after clear");
        rd_chk(imm_pkg::OFF_ISR, 32'h0000_0010, "isr after clear");
        $display("test irq done");
    endtask
    task automatic t_wrap;
        mem.wait_cyc = 2;
        for (int i = 0; i < 5; i++) mem.mem[12'h100 + i] = 32'h0;
        setup(12'h80, 32'h0000_0001, 32'h0);
        apb(imm_pkg::OFF_DSCR, 1'b1, 32'h0000_0200);
        apb(imm_pkg::OFF_CTRL, 1'b1, 32'h1);
        while (sum_rd(12'h80, 12'h83) < 32'd12) @(posedge REF_CLK);
        apb(imm_pkg::OFF_CTRL, 1'b1, 32'h3);
        wait_idle;
        chk(sum_rd(12'h84, 12'h8F), 32'h0, "wrap restarts at first");
        chk(sum_rd(12'h80, 12'h83) % 32'd4, 32'h0, "whole descriptors");
        for (int i = 0; i < 5; i++) chk(mem.mem[12'h100 + i], SHA1_ABC[i], "slow digest");
        $display("test wrap done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge REF_CLK);
        num_errors++;
        $display("unexpected at %0t: run timed out", $time);
        results();
    end
    initial begin
        RST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        repeat (16) @(posedge REF_CLK);
        RST <= 1'b0;
        t_regs();
        t_list();
        t_irq();
        t_wrap();
        results();
    end
endmodule

// ### logic/imm_pkg.sv
// constants, types and tables shared by the integrity monitor
package imm_pkg;
    // ----------------------------------------
    // register map (byte offsets)
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_DSCR = 8'h08;
    localparam logic [7:0] OFF_HASH = 8'h0C;
    localparam logic [7:0] OFF_IER = 8'h10;
    localparam logic [7:0] OFF_ISR = 8'h14;
    localparam logic [7:0] OFF_ICR = 8'h18;
    localparam int CTRL_EN = 0;
    localparam int CTRL_DIS = 1;
    localparam int NEV = 5;
    localparam int EV_EOM = 4;
    // ----------------------------------------
    // descriptor layout
    // ----------------------------------------
    localparam int CFG_WRAP = 0;
    localparam int CFG_EOM = 1;
    localparam int CFG_CMP = 2;
    localparam int CFG_ALG = 4;
    localparam int NREG = 4;
    localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
    localparam logic [31:0] DIG_STRIDE = 32'h0000_0020;
    localparam logic [31:0] BLK_BYTES = 32'h0000_0040;
    localparam logic [1:0] ALG_SHA1 = 2'h0;
    localparam logic [1:0] ALG_SHA224 = 2'h2;
    localparam logic [6:0] RND_SHA1 = 7'h50;
    localparam logic [6:0] RND_SHA2 = 7'h40;
    localparam logic [3:0] DIG_SHA1 = 4'h5;
    localparam logic [3:0] DIG_SHA224 = 4'h7;
    localparam logic [3:0] DIG_SHA256 = 4'h8;
    // ----------------------------------------
    // hash tables
    // ----------------------------------------
    localparam logic [0:7][31:0] IV1 = {32'h67452301, 32'hEFCDAB89, 32'h98BADCFE,
        32'h10325476, 32'hC3D2E1F0, 32'h00000000, 32'h00000000, 32'h00000000};
    localparam logic [0:7][31:0] IV224 = {32'hC1059ED8, 32'h367CD507, 32'h3070DD17,
        32'hF70E5939, 32'hFFC00B31, 32'h68581511, 32'h64F98FA7, 32'hBEFA4FA4};
    localparam logic [0:7][31:0] IV256 = {32'h6A09E667, 32'hBB67AE85, 32'h3C6EF372,
        32'hA54FF53A, 32'h510E527F, 32'h9B05688C, 32'h1F83D9AB, 32'h5BE0CD19};
    localparam logic [0:3][31:0] K1 = {32'h5A827999, 32'h6ED9EBA1, 32'h8F1BBCDC,
        32'hCA62C1D6};
    localparam logic [0:63][31:0] K256 = {
        32'h428A2F98, 32'h71374491, 32'hB5C0FBCF, 32'hE9B5DBA5, 32'h3956C25B,
        32'h59F111F1, 32'h923F82A4, 32'hAB1C5ED5, 32'hD807AA98, 32'h12835B01,
        32'h243185BE, 32'h550C7DC3, 32'h72BE5D74, 32'h80DEB1FE, 32'h9BDC06A7,
        32'hC19BF174, 32'hE49B69C1, 32'hEFBE4786, 32'h0FC19DC6, 32'h240CA1CC,
        32'h2DE92C6F, 32'h4A7484AA, 32'h5CB0A9DC, 32'h76F988DA, 32'h983E5152,
        32'hA831C66D, 32'hB00327C8, 32'hBF597FC7, 32'hC6E00BF3, 32'hD5A79147,
        32'h06CA6351, 32'h14292967, 32'h27B70A85, 32'h2E1B2138, 32'h4D2C6DFC,
        32'h53380D13, 32'h650A7354, 32'h766A0ABB, 32'h81C2C92E, 32'h92722C85,
        32'hA2BFE8A1, 32'hA81A664B, 32'hC24B8B70, 32'hC76C51A3, 32'hD192E819,
        32'hD6990624, 32'hF40E3585, 32'h106AA070, 32'h19A4C116, 32'h1E376C08,
        32'h2748774C, 32'h34B0BCB5, 32'h391C0CB3, 32'h4ED8AA4A, 32'h5B9CCA4F,
        32'h682E6FF3, 32'h748F82EE, 32'h78A5636F, 32'h84C87814, 32'h8CC70208,
        32'h90BEFFFA, 32'hA4506CEB, 32'hBEF9A3F7, 32'hC67178F2};
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        IMM_IDLE, IMM_DESC, IMM_LOAD, IMM_ROUND, IMM_ADD, IMM_DIG, IMM_NEXT
    } imm_fsm_t;
    typedef struct packed {
        logic [31:0] addr;
        logic wrap;
        logic end_of_monitoring_flag;
        logic cmp;
        logic [1:0] alg;
        logic [15:0] blocks;
    } imm_desc_t;
    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } imm_mem_t;
    typedef struct packed {
        imm_fsm_t st;
        logic en;
        logic [31:0] dscr;
        logic [31:0] hbase;
        logic [NEV-1:0] ier;
        logic [NEV-1:0] isr;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        imm_mem_t mem;
        imm_desc_t d;
        logic [1:0] idx;
        logic [3:0] wc;
        logic [6:0] rnd;
        logic [16:0] left;
        logic miss;
        logic [15:0][31:0] w;
        logic [7:0][31:0] v;
        logic [7:0][31:0] hh;
    } imm_state_t;
endpackage

// ### logic/imm_top.sv
// integrity monitor: descriptor walker, sha engine, apb registers
//
// Overview of operation
// - digest is 160, 224 or 256 bits
// - when enabled, fetch descriptors from circular list
// - at most four regions supervised
// - four-word descriptor holds layout and hash setup
// - hash only after descriptor fetched into context
// - hash the programmed number of blocks plus one
// - per region, write digest back or compare
// - mismatch sets flag, interrupt only if unmasked
// - walk descriptors until end flag or disable; wrap restarts at the first
module imm_top (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [31:0] MEM_ADDR,
    output logic [31:0] MEM_WDATA,
    input wire logic MEM_ACK,
    input wire logic [31:0] MEM_RDATA,
    output logic IRQ
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rotr(input logic [31:0] x, input int n);
        rotr = (x >> n) | (x << (32 - n));
    endfunction

    function automatic logic [3:0] ndig(input logic [1:0] alg);
        if (alg == imm_pkg::ALG_SHA1) begin
            ndig = imm_pkg::DIG_SHA1;
        end else if (alg == imm_pkg::ALG_SHA224) begin
            ndig = imm_pkg::DIG_SHA224;
        end else begin
            ndig = imm_pkg::DIG_SHA256;
        end
    endfunction

    // byte address of word wc in slot idx of a table with a fixed stride
    function automatic logic [31:0] slot_addr(input logic [31:0] base, input logic [1:0] idx,
        input logic [31:0] stride, input logic [3:0] wc);
        slot_addr = base + {30'h0, idx} * stride + {26'h0, wc, 2'h0};
    endfunction

    // register decode, shared by read and write paths
    function automatic logic [2:0] rsel(input logic [7:0] a);
        unique case (a)
            imm_pkg::OFF_CTRL: rsel = 3'h0;
            imm_pkg::OFF_STAT: rsel = 3'h1;
            imm_pkg::OFF_DSCR: rsel = 3'h2;
            imm_pkg::OFF_HASH: rsel = 3'h3;
            imm_pkg::OFF_IER: rsel = 3'h4;
            imm_pkg::OFF_ISR: rsel = 3'h5;
            imm_pkg::OFF_ICR: rsel = 3'h6;
            default: rsel = 3'h7;
        endcase
    endfunction

    imm_pkg::imm_state_t s_r;
    imm_pkg::imm_state_t s_nxt;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic wr;
        logic [2:0] sel;
        logic [imm_pkg::NEV-1:0] set;
        logic [imm_pkg::NEV-1:0] clr;
        logic [31:0] t1;
        logic [31:0] t2;
        logic [31:0] wn;
        logic [31:0] f;
        logic [31:0] k;
        logic [31:0] s0;
        logic [31:0] s1;
        logic sha1;
        logic [6:0] last;
        logic [0:7][31:0] iv;
        s_nxt = s_r;
        wr = PSEL && PENABLE && s_r.pready && PWRITE;
        sel = rsel(PADDR);
        set = '0;
        clr = '0;
        t1 = '0;
        t2 = '0;
        wn = '0;
        f = '0;
        k = '0;
        s0 = '0;
        s1 = '0;
        sha1 = (s_r.d.alg == imm_pkg::ALG_SHA1);
        last = sha1 ? imm_pkg::RND_SHA1 - 7'h01 : imm_pkg::RND_SHA2 - 7'h01;
        iv = sha1 ? imm_pkg::IV1 :
            (s_r.d.alg == imm_pkg::ALG_SHA224) ? imm_pkg::IV224 : imm_pkg::IV256;

        // ----------------------------------------
        // apb slave: zero wait state, answer prepared in setup
        // ----------------------------------------
        s_nxt.pready = PSEL && !PENABLE;
        // the error flag stands only with ready, never past the access cycle
        s_nxt.pslverr = PSEL && !PENABLE && (sel == 3'h7);
        if (PSEL && !PENABLE) begin
            unique case (sel)
                3'h1: s_nxt.prdata = {28'h0, s_r.idx, s_r.st != imm_pkg::IMM_IDLE, s_r.en};
                3'h2: s_nxt.prdata = s_r.dscr;
                3'h3: s_nxt.prdata = s_r.hbase;
                3'h4: s_nxt.prdata = {27'h0, s_r.ier};
                3'h5: s_nxt.prdata = {27'h0, s_r.isr};
                default: s_nxt.prdata = 32'h0;
            endcase
        end
        if (wr) begin
            unique case (sel)
                3'h0: begin
                    if (PWDATA[imm_pkg::CTRL_EN]) begin
                        s_nxt.en = 1'b1;
                    end
                    // disable wins; the walk stops at the next region boundary
                    if (PWDATA[imm_pkg::CTRL_DIS]) begin
                        s_nxt.en = 1'b0;
                    end
                end
                3'h2: s_nxt.dscr = PWDATA;
                3'h3: s_nxt.hbase = PWDATA;
                3'h4: s_nxt.ier = PWDATA[imm_pkg::NEV-1:0];
                3'h6: clr = PWDATA[imm_pkg::NEV-1:0];
                default: ;
            endcase
        end

        // ----------------------------------------
        // memory handshake: request held until ack
        // ----------------------------------------
        if (s_r.mem.req && MEM_ACK) begin
            s_nxt.mem.req = 1'b0;
            s_nxt.mem.we = 1'b0;
            s_nxt.wc = s_r.wc + 4'h1;
        end

        // ----------------------------------------
        // monitoring sequencer
        // ----------------------------------------
        unique case (s_r.st)
            imm_pkg::IMM_IDLE: begin
                if (s_r.en) begin
                    s_nxt.idx = 2'h0;
                    s_nxt.wc = 4'h0;
                    s_nxt.st = imm_pkg::IMM_DESC;
                end
            end
            imm_pkg::IMM_DESC: begin
                // four words per descriptor: address, config, control, spare
                if (!s_r.mem.req && s_r.wc == 4'h4) begin
                    // context loaded, hashing may start now
                    // element by element: the table runs 0 to 7, the state 7 down to 0
                    for (int i = 0; i < 8; i++) begin
                        s_nxt.hh[i] = iv[i];
                    end
                    s_nxt.left = {1'b0, s_r.d.blocks} + 17'h1;
                    s_nxt.wc = 4'h0;
                    s_nxt.miss = 1'b0;
                    s_nxt.st = imm_pkg::IMM_LOAD;
                end else if (!s_r.mem.req) begin
                    s_nxt.mem.req = 1'b1;
                    s_nxt.mem.addr = slot_addr(s_r.dscr, s_r.idx, imm_pkg::DESC_STRIDE,
                        s_r.wc);
                end else if (MEM_ACK) begin
                    unique case (s_r.wc)
                        4'h0: s_nxt.d.addr = MEM_RDATA;
                        4'h1: begin
                            s_nxt.d.wrap = MEM_RDATA[imm_pkg::CFG_WRAP];
                            s_nxt.d.end_of_monitoring_flag = MEM_RDATA[imm_pkg::CFG_EOM];
                            s_nxt.d.cmp = MEM_RDATA[imm_pkg::CFG_CMP];
                            s_nxt.d.alg = MEM_RDATA[imm_pkg::CFG_ALG +: 2];
                        end
                        4'h2: s_nxt.d.blocks = MEM_RDATA[15:0];
                        default: ;
                    endcase
                end
            end
            imm_pkg::IMM_LOAD: begin
                if (!s_r.mem.req && s_r.wc == 4'h0 && s_r.rnd == 7'h7F) begin
                    s_nxt.rnd = 7'h0;
                    s_nxt.v = s_r.hh;
                    s_nxt.st = imm_pkg::IMM_ROUND;
                end else if (!s_r.mem.req) begin
                    s_nxt.mem.req = 1'b1;
                    s_nxt.mem.addr = s_r.d.addr + {26'h0, s_r.wc, 2'h0};
                end else if (MEM_ACK) begin
                    s_nxt.w[s_r.wc] = MEM_RDATA;
                    // wc wraps to zero after word 15; rnd marks the block full
                    if (s_r.wc == 4'hF) begin
                        s_nxt.rnd = 7'h7F;
                    end
                end
            end
            imm_pkg::IMM_ROUND: begin
                if (sha1) begin
                    unique case (s_r.rnd / 7'd20)
                        7'd0: f = (s_r.v[1] & s_r.v[2]) | (~s_r.v[1] & s_r.v[3]);
                        7'd2: f = (s_r.v[1] & s_r.v[2]) | (s_r.v[1] & s_r.v[3])
                            | (s_r.v[2] & s_r.v[3]);
                        default: f = s_r.v[1] ^ s_r.v[2] ^ s_r.v[3];
                    endcase
                    k = imm_pkg::K1[2'(s_r.rnd / 7'd20)];
                    t1 = rotr(s_r.v[0], 27) + f + s_r.v[4] + k + s_r.w[0];
                    wn = rotr(s_r.w[13] ^ s_r.w[8] ^ s_r.w[2] ^ s_r.w[0], 31);
                    s_nxt.v = {96'h0, s_r.v[3], s_r.v[2], rotr(s_r.v[1], 2), s_r.v[0], t1};
                end else begin
                    s1 = rotr(s_r.v[4], 6) ^ rotr(s_r.v[4], 11) ^ rotr(s_r.v[4], 25);
                    f = (s_r.v[4] & s_r.v[5]) ^ (~s_r.v[4] & s_r.v[6]);
                    t1 = s_r.v[7] + s1 + f + imm_pkg::K256[6'(s_r.rnd)] + s_r.w[0];
                    s0 = rotr(s_r.v[0], 2) ^ rotr(s_r.v[0], 13) ^ rotr(s_r.v[0], 22);
                    t2 = s0 + ((s_r.v[0] & s_r.v[1]) ^ (s_r.v[0] & s_r.v[2])
                        ^ (s_r.v[1] & s_r.v[2]));
                    s_nxt.v = {s_r.v[6:4], s_r.v[3] + t1, s_r.v[2:0], t1 + t2};
                    s0 = rotr(s_r.w[1], 7) ^ rotr(s_r.w[1], 18) ^ (s_r.w[1] >> 3);
                    s1 = rotr(s_r.w[14], 17) ^ rotr(s_r.w[14], 19) ^ (s_r.w[14] >> 10);
                    wn = s1 + s_r.w[9] + s0 + s_r.w[0];
                end
                s_nxt.w = {wn, s_r.w[15:1]};
                s_nxt.rnd = s_r.rnd + 7'h1;
                if (s_r.rnd == last) begin
                    s_nxt.st = imm_pkg::IMM_ADD;
                end
            end
            imm_pkg::IMM_ADD: begin
                for (int i = 0; i < 8; i++) begin
                    s_nxt.hh[i] = s_r.hh[i] + s_r.v[i];
                end
                s_nxt.left = s_r.left - 17'h1;
                s_nxt.d.addr = s_r.d.addr + imm_pkg::BLK_BYTES;
                s_nxt.rnd = 7'h0;
                s_nxt.wc = 4'h0;
                // stop after the programmed block count plus one
                if (s_r.left == 17'h1) begin
                    s_nxt.st = imm_pkg::IMM_DIG;
                end else begin
                    s_nxt.st = imm_pkg::IMM_LOAD;
                end
            end
            imm_pkg::IMM_DIG: begin
                // digest length follows the region's algorithm
                if (!s_r.mem.req && s_r.wc == ndig(s_r.d.alg)) begin
                    s_nxt.st = imm_pkg::IMM_NEXT;
                end else if (!s_r.mem.req) begin
                    s_nxt.mem.req = 1'b1;
                    s_nxt.mem.we = !s_r.d.cmp;
                    s_nxt.mem.wdata = s_r.hh[s_r.wc[2:0]];
                    s_nxt.mem.addr = slot_addr(s_r.hbase, s_r.idx, imm_pkg::DIG_STRIDE,
                        s_r.wc);
                end else if (MEM_ACK && s_r.d.cmp) begin
                    if (MEM_RDATA != s_r.hh[s_r.wc[2:0]]) begin
                        s_nxt.miss = 1'b1;
                    end
                end
            end
            imm_pkg::IMM_NEXT: begin
                set[s_r.idx] = s_r.miss;
                s_nxt.wc = 4'h0;
                if (s_r.d.end_of_monitoring_flag || !s_r.en) begin
                    set[imm_pkg::EV_EOM] = s_r.d.end_of_monitoring_flag;
                    s_nxt.en = 1'b0;
                    s_nxt.st = imm_pkg::IMM_IDLE;
                end else if (s_r.d.wrap || s_r.idx == 2'(imm_pkg::NREG - 1)) begin
                    // a fifth region does not exist: the list closes on itself
                    s_nxt.idx = 2'h0;
                    s_nxt.st = imm_pkg::IMM_DESC;
                end else begin
                    s_nxt.idx = s_r.idx + 2'h1;
                    s_nxt.st = imm_pkg::IMM_DESC;
                end
            end
            default: s_nxt.st = imm_pkg::IMM_IDLE;
        endcase

        // ----------------------------------------
        // interrupt: a new event beats a clear in the same cycle
        // ----------------------------------------
        s_nxt.isr = (s_r.isr & ~clr) | set;
        s_nxt.irq = |(s_nxt.isr & s_nxt.ier);
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            s_r <= '0;
            s_r.st <= imm_pkg::IMM_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // outputs, each straight from the state register
    // ----------------------------------------
    assign PRDATA = s_r.prdata;
    assign PREADY = s_r.pready;
    assign PSLVERR = s_r.pslverr;
    assign MEM_REQ = s_r.mem.req;
    assign MEM_WE = s_r.mem.we;
    assign MEM_ADDR = s_r.mem.addr;
    assign MEM_WDATA = s_r.mem.wdata;
    assign IRQ = s_r.irq;
endmodule
